// ### rtl/addr_gen_pkg.sv
// constants and types for the cpu address generation block
package addr_gen_pkg;
  localparam logic [15:0] RESET_PC        = 16'h0000;
  localparam logic [15:0] RESET_SP        = 16'hfeff;
  localparam logic [15:0] TABLE_BASE      = 16'h0040;
  localparam logic [15:0] SHORT_BASE_RAM  = 16'hfe00;
  localparam logic [15:0] SHORT_BASE_SFR  = 16'hff00;
  localparam logic [7:0]  SHORT_SFR_LIMIT = 8'h20;
  localparam logic [15:0] SPECIAL_BASE    = 16'hff00;
  localparam logic [15:0] FAST_RAM_LO     = 16'hfe20;
  localparam logic [15:0] FAST_RAM_HI     = 16'hfeff;
  localparam logic [15:0] WIDE_TIMER_LO   = 16'hff16;
  localparam logic [15:0] WIDE_TIMER_HI   = 16'hff1b;
  localparam int          TABLE_LSB       = 1;
  localparam int          TABLE_MSB       = 5;
  localparam logic [1:0]  PAIR_ACC        = 2'd0;
  localparam logic [1:0]  PAIR_SECOND     = 2'd2;
  localparam logic [1:0]  PAIR_BASE       = 2'd3;

  typedef enum logic [2:0] {
    PC_HOLD, PC_SEQ, PC_REL, PC_IMM, PC_TABLE, PC_REG, PC_LOAD
  } pc_op_t;

  typedef enum logic [3:0] {
    OPA_NONE, OPA_DIRECT, OPA_SHORT, OPA_SPECIAL, OPA_REG_IND,
    OPA_BASED, OPA_PUSH, OPA_POP
  } opa_mode_t;
endpackage

// ### rtl/reg_decode.sv
// general register and register pair select decoder
module reg_decode
  import addr_gen_pkg::*;
(
  input  wire logic [2:0] i_reg_code,
  input  wire logic [1:0] i_pair_code,
  input  wire logic [63:0] i_regs,
  output logic      [7:0] o_reg_val,
  output logic      [15:0] o_pair_val
);
  always_comb begin
    o_reg_val  = i_regs[i_reg_code*8 +: 8];
    o_pair_val = i_regs[i_pair_code*16 +: 16];
  end
endmodule // reg_decode

// ### rtl/cpu_address_generation.sv
// program counter and operand effective address generation
// Function
// - sequential fetch adds one per byte
// - relative branch adds sign-extended displacement
// - short branch and conditionals use relative
// - absolute call/jump loads 16-bit immediate
// - table word low byte even address
// - register jump loads accumulator pair
// - direct addressing uses 16-bit immediate
// - short direct window fe20h to ff1fh
// - bit 8 set for fields below 20h
// - special register address is ff00h plus field
// - 3-bit register code, 2-bit pair code
// - indirect through second or base pair
// - based adds zero-extended offset, no carry
// - stack accesses outside fast ram fe20h to feffh raise a fault
// - predecrement on save, postincrement restore
// - wide timer word access only short direct; register indirect and based word accesses to it raise no fault
// - wide timer byte access via direct
module cpu_address_generation
  import addr_gen_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire addr_gen_pkg::pc_op_t i_pc_op,
  input  wire logic                i_fetch,
  input  wire logic                i_branch_taken,
  input  wire logic [7:0]          i_branch_displacement,
  input  wire logic [15:0]         i_imm16,
  input  wire logic [7:0]          i_imm8,
  input  wire logic [7:0]          i_table_call_instr,
  input  wire logic [7:0]          i_table_lo,
  input  wire logic [7:0]          i_table_hi,
  input  wire addr_gen_pkg::opa_mode_t i_opa_mode,
  input  wire logic                i_opa_word,
  input  wire logic                i_pair_sel_base,
  input  wire logic [2:0]          i_reg_code,
  input  wire logic [1:0]          i_pair_code,
  input  wire logic [63:0]         i_regs,
  input  wire logic                i_sp_load,
  input  wire logic [15:0]         i_sp_value,
  output logic      [15:0]         o_program_counter,
  output logic      [15:0]         o_table_addr,
  output logic      [15:0]         o_operand_addr,
  output logic                     o_operand_valid,
  output logic                     o_access_fault,
  output logic      [15:0]         o_stack_pointer,
  output logic      [7:0]          o_reg_val,
  output logic      [15:0]         o_pair_val
);
  import addr_gen_pkg::*;

  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] sp_ff, nxt_sp;
  logic [15:0] opa_ff, nxt_opa;
  logic        opv_ff, nxt_opv;
  logic        flt_ff, nxt_flt;
  logic [15:0] tba_ff, nxt_tba;
  logic [7:0]  rv_ff,  nxt_rv;
  logic [15:0] pv_ff,  nxt_pv;
  logic [7:0]  reg_val;
  logic [15:0] pair_val;
  logic [15:0] acc_pair, second_pair, base_pair;

  function automatic logic [15:0] short_addr(input logic [7:0] f);
    short_addr = (f < SHORT_SFR_LIMIT) ? (SHORT_BASE_SFR | {8'h00, f})
                                       : (SHORT_BASE_RAM | {8'h00, f});
  endfunction

  function automatic logic in_wide_timer(input logic [15:0] a);
    in_wide_timer = (a >= WIDE_TIMER_LO) && (a <= WIDE_TIMER_HI);
  endfunction

  reg_decode u_dec (
    .i_reg_code (i_reg_code),
    .i_pair_code(i_pair_code),
    .i_regs     (i_regs),
    .o_reg_val  (reg_val),
    .o_pair_val (pair_val)
  );

  assign acc_pair    = i_regs[PAIR_ACC*16 +: 16];
  assign second_pair = i_regs[PAIR_SECOND*16 +: 16];
  assign base_pair   = i_regs[PAIR_BASE*16 +: 16];

  // program counter group
  always_comb begin
    nxt_pc  = pc_ff;
    nxt_tba = tba_ff;
    unique case (i_pc_op)
      PC_HOLD: nxt_pc = pc_ff;
      PC_SEQ: nxt_pc = i_fetch ? pc_ff + 16'h0001 : pc_ff;
      PC_REL: nxt_pc = i_branch_taken ?
        pc_ff + {{8{i_branch_displacement[7]}}, i_branch_displacement}
        : pc_ff;
      PC_IMM: nxt_pc = i_imm16;
      // low byte even, high byte odd
      PC_TABLE: nxt_pc = {i_table_hi, i_table_lo};
      PC_REG: nxt_pc = acc_pair;
      PC_LOAD: nxt_pc = {i_table_hi, i_table_lo};
    endcase
    nxt_tba = TABLE_BASE |
      {10'h000, i_table_call_instr[TABLE_MSB:TABLE_LSB], 1'b0};
    if (i_rst) begin
      nxt_pc  = RESET_PC;
      nxt_tba = TABLE_BASE;
    end
  end

  always_ff @(posedge i_clk) begin
    pc_ff  <= nxt_pc;
    tba_ff <= nxt_tba;
  end

  // operand and stack group
  always_comb begin
    nxt_sp  = sp_ff;
    nxt_opa = opa_ff;
    nxt_opv = 1'b1;
    nxt_flt = 1'b0;
    unique case (i_opa_mode)
      OPA_NONE: nxt_opv = 1'b0;
      // direct, byte access to timer ok
      OPA_DIRECT: begin
        nxt_opa = i_imm16;
        // no word access outside short direct
        nxt_flt = i_opa_word && in_wide_timer(i_imm16);
      end
      OPA_SHORT: begin
        nxt_opa = short_addr(i_imm8);
        nxt_flt = i_opa_word && i_imm8[0];
      end
      OPA_SPECIAL: begin
        nxt_opa = SPECIAL_BASE | {8'h00, i_imm8};
        nxt_flt = i_opa_word && in_wide_timer(SPECIAL_BASE |
                                              {8'h00, i_imm8});
      end
      OPA_REG_IND: nxt_opa = i_pair_sel_base ? base_pair : second_pair;
      // carry out dropped by 16-bit width
      OPA_BASED: nxt_opa = base_pair + {8'h00, i_imm8};
      OPA_PUSH: begin
        nxt_sp  = sp_ff - 16'h0001;
        nxt_opa = sp_ff - 16'h0001;
        nxt_flt = (nxt_opa < FAST_RAM_LO) || (nxt_opa > FAST_RAM_HI);
      end
      OPA_POP: begin
        nxt_sp  = sp_ff + 16'h0001;
        nxt_opa = sp_ff;
        nxt_flt = (sp_ff < FAST_RAM_LO) || (sp_ff > FAST_RAM_HI);
      end
      default: nxt_opv = 1'b0;
    endcase
    if (i_sp_load) begin
      nxt_sp = i_sp_value;
    end
    if (i_rst) begin
      nxt_sp  = RESET_SP;
      nxt_opa = 16'h0000;
      nxt_opv = 1'b0;
      nxt_flt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    sp_ff  <= nxt_sp;
    opa_ff <= nxt_opa;
    opv_ff <= nxt_opv;
    flt_ff <= nxt_flt;
  end

  always_comb begin
    nxt_rv = i_rst ? 8'h00 : reg_val;
    nxt_pv = i_rst ? 16'h0000 : pair_val;
  end

  always_ff @(posedge i_clk) begin
    rv_ff <= nxt_rv;
    pv_ff <= nxt_pv;
  end

  assign o_program_counter = pc_ff;
  assign o_table_addr      = tba_ff;
  assign o_operand_addr    = opa_ff;
  assign o_operand_valid   = opv_ff;
  assign o_access_fault    = flt_ff;
  assign o_stack_pointer   = sp_ff;
  assign o_reg_val         = rv_ff;
  assign o_pair_val        = pv_ff;

  // checks
  AST_SEQ: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pc_op == PC_SEQ && i_fetch) |=> pc_ff == $past(pc_ff) + 16'h0001)
    else $error("pc did not advance by one");
  AST_REL: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pc_op == PC_REL && i_branch_taken) |=> pc_ff == $past(pc_ff) +
      {{8{$past(i_branch_displacement[7])}}, $past(i_branch_displacement)})
    else $error("relative target wrong");
  AST_IMM: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pc_op == PC_IMM) |=> pc_ff == $past(i_imm16))
    else $error("absolute target wrong");
  AST_TBL: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> tba_ff[15:7] == 9'h000 && tba_ff[6] && !tba_ff[0])
    else $error("table address out of area");
  AST_REG: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pc_op == PC_REG) |=> pc_ff == $past(acc_pair))
    else $error("register jump wrong");
  AST_SHORT: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_opa_mode == OPA_SHORT) |=> opa_ff[15:9] == 7'h7f &&
      opa_ff[8] == ($past(i_imm8) < 8'h20))
    else $error("short direct bit 8 wrong");
  AST_SFR: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_opa_mode == OPA_SPECIAL) |=> opa_ff == {8'hff, $past(i_imm8)})
    else $error("special register address wrong");
  AST_BASED: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_opa_mode == OPA_BASED) |=>
      opa_ff == 16'($past(base_pair) + {8'h00, $past(i_imm8)}))
    else $error("based address wrong");
  AST_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_opa_mode == OPA_PUSH && !i_sp_load) |=>
      opa_ff == sp_ff && sp_ff == $past(sp_ff) - 16'h0001)
    else $error("push not predecremented");
  AST_WORD: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_opa_mode == OPA_DIRECT && i_opa_word &&
     i_imm16 == WIDE_TIMER_LO) |=> flt_ff)
    else $error("wide timer word via direct not refused");
  COV_REL: cover property (@(posedge i_clk)
    i_pc_op == PC_REL && i_branch_taken && i_branch_displacement[7]);
  COV_TBL: cover property (@(posedge i_clk) i_pc_op == PC_TABLE);
  COV_PUSHPOP: cover property (@(posedge i_clk)
    i_opa_mode == OPA_PUSH ##1 i_opa_mode == OPA_POP);
endmodule // cpu_address_generation

// ### testbench/table_mem.sv
// table memory model answering word reads for call and vector tables
module table_mem (
  input  wire logic [15:0] i_addr,
  output logic      [7:0]  o_lo,
  output logic      [7:0]  o_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    o_lo = {i_addr[7:1], 1'b0} ^ 8'h5a;
    o_hi = {i_addr[7:1], 1'b1} ^ 8'h5a;
  end
endmodule // table_mem

// ### testbench/tb.sv
// self-checking bench for the address generation block
module tb;
  import addr_gen_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0, i_rst = 1'b1;
  pc_op_t      i_pc_op = PC_HOLD;
  opa_mode_t   i_opa_mode = OPA_NONE;
  logic        i_fetch = 0, i_branch_taken = 0, i_opa_word = 0;
  logic        i_pair_sel_base = 0, i_sp_load = 0;
  logic [7:0]  i_branch_displacement = 0, i_imm8 = 0;
  logic [7:0]  i_table_call_instr = 0, i_table_lo, i_table_hi, m_reg;
  logic [2:0]  i_reg_code = 0;
  logic [1:0]  i_pair_code = 0;
  logic [15:0] i_imm16 = 0, i_sp_value = 0, m_pc, m_sp, m_tab, m_op, m_pair;
  logic [15:0] o_program_counter, o_table_addr, o_operand_addr;
  logic [15:0] o_stack_pointer, o_pair_val, a, s;
  logic [63:0] i_regs = 0;
  logic [7:0]  o_reg_val;
  logic        o_operand_valid, o_access_fault, m_val, m_flt;
  logic [31:0] seed = 32'h81619ca6, r;
  int          n_errors = 0, num_checks = 0;

  always #4 i_clk = ~i_clk;

  cpu_address_generation DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_pc_op(i_pc_op), .i_fetch(i_fetch), .i_branch_taken(i_branch_taken),
    .i_branch_displacement(i_branch_displacement), .i_imm16(i_imm16),
    .i_imm8(i_imm8), .i_table_call_instr(i_table_call_instr),
    .i_table_lo(i_table_lo), .i_table_hi(i_table_hi),
    .i_opa_mode(i_opa_mode), .i_opa_word(i_opa_word),
    .i_pair_sel_base(i_pair_sel_base), .i_reg_code(i_reg_code),
    .i_pair_code(i_pair_code), .i_regs(i_regs), .i_sp_load(i_sp_load),
    .i_sp_value(i_sp_value), .o_program_counter(o_program_counter),
    .o_table_addr(o_table_addr), .o_operand_addr(o_operand_addr),
    .o_operand_valid(o_operand_valid), .o_access_fault(o_access_fault),
    .o_stack_pointer(o_stack_pointer), .o_reg_val(o_reg_val),
    .o_pair_val(o_pair_val));

  table_mem PART (.i_addr(o_table_addr), .o_lo(i_table_lo),
    .o_hi(i_table_hi));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reset_model();
    {m_pc, m_op, m_reg, m_pair, m_val, m_flt} = '0;
    m_sp = 16'hfeff;
    m_tab = 16'h0040;
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    reset_model();
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge i_clk);
      chk("pc", o_program_counter, m_pc);
      chk("table", o_table_addr, m_tab);
      chk("operand", o_operand_addr, m_op);
      chk("valid", 16'(o_operand_valid), 16'(m_val));
      chk("fault", 16'(o_access_fault), 16'(m_flt));
      chk("sp", o_stack_pointer, m_sp);
      chk("reg", 16'(o_reg_val), 16'(m_reg));
      chk("pair", o_pair_val, m_pair);
      r = rnd();
      i_rst = (i == 2000);
      i_pc_op = pc_op_t'(r[2:0] % 7);
      {i_branch_taken, i_fetch} = r[4:3];
      i_branch_displacement = r[15:8];
      {i_table_call_instr, i_imm8, i_imm16} = rnd();
      r = rnd();
      i_opa_mode = opa_mode_t'(r[2:0]);
      i_opa_word = r[3] & (r[2:1] != 2'b11);
      {i_pair_code, i_reg_code, i_pair_sel_base} = r[9:4];
      i_sp_load = (r[15:10] == 0);
      i_sp_value = {8'hfe, r[23:16] | 8'h20};
      // wide timer addresses ff16h to ff1bh offered on purpose to see the fault
      if (r[27:26] == 0) begin
        i_imm16 = 16'hff16 + 16'(r[30:28] % 6);
        i_imm8 = i_imm16[7:0];
      end
      i_regs = {rnd(), rnd()};
      case (i_pc_op)
        PC_SEQ: if (i_fetch) m_pc = m_pc + 16'h0001;
        PC_REL: if (i_branch_taken)
          m_pc = m_pc + {{8{i_branch_displacement[7]}}, i_branch_displacement};
        PC_IMM: m_pc = i_imm16;
        PC_TABLE, PC_LOAD: m_pc = {m_tab[7:0] ^ 8'h5b, m_tab[7:0] ^ 8'h5a};
        PC_REG: m_pc = i_regs[15:0];
        default: ;
      endcase
      m_tab = 16'h0040 + {10'h000, i_table_call_instr[5:1], 1'b0};
      a = m_op;
      s = m_sp;
      case (i_opa_mode)
        OPA_DIRECT: a = i_imm16;
        OPA_SHORT: a = {7'h7f, i_imm8 < 8'h20, i_imm8};
        OPA_SPECIAL: a = {8'hff, i_imm8};
        OPA_REG_IND: a = i_pair_sel_base ? i_regs[63:48] : i_regs[47:32];
        OPA_BASED: a = i_regs[63:48] + {8'h00, i_imm8};
        OPA_PUSH: begin s = m_sp - 16'h0001; a = s; end
        OPA_POP: begin a = m_sp; s = m_sp + 16'h0001; end
        default: ;
      endcase
      m_flt = (i_opa_word && a >= 16'hff16 && a <= 16'hff1b &&
        i_opa_mode != OPA_SHORT && i_opa_mode != OPA_NONE) ||
        (i_opa_word && i_opa_mode == OPA_SHORT && a[0]) ||
        (i_opa_mode >= OPA_PUSH && (a < 16'hfe20 || a > 16'hfeff));
      m_op = a;
      m_sp = i_sp_load ? i_sp_value : s;
      m_val = (i_opa_mode != OPA_NONE);
      m_reg = i_regs[8*i_reg_code +: 8];
      m_pair = i_regs[16*i_pair_code +: 16];
      if (i_rst) reset_model();
    end
    tally_and_finish();
  end
endmodule // tb
